// ==== hdl/lpm_consts.svh ====
// Purpose: Constants for the low-power mode controller.
// Assumes: Counts are in processor bus clock cycles.
// Notes:   Included by bare name.
`ifndef LPM_CONSTS_SVH
`define LPM_CONSTS_SVH
`define LPM_LONG_DELAY  12'd4064
`define LPM_SHORT_DELAY 12'd16
`define LPM_CNT_W       12
`endif

// ==== hdl/lpm_pkg.sv ====
// Purpose: Types for the low-power mode controller.
// Assumes: Nothing.
// Notes:   Constants live in lpm_consts.svh.
package lpm_pkg;
  typedef enum logic [2:0] {
    LPM_RUN,
    LPM_STOP,
    LPM_HALT,
    LPM_WAIT,
    LPM_STAB,
    LPM_HALT_EXIT
  } lpm_state_e;
endpackage

// ==== hdl/lpm_ctrl.sv ====
// Purpose: Low-power mode control: stop, halt and wait entry, clock gating, wake-up delay.
// Assumes: Core requests are one-cycle pulses on clk_in; irq and timer inputs are async.
// Notes:   Clock gating is expressed as enables; the gate cells sit outside.
// Functional notes
// - Stop request enters stop when select bit clear, otherwise halt.
// - Stop mode turns oscillator off and freezes the watchdog counter.
// - Stop entry clears both timer flags and both timer interrupt enables.
// - Stop instruction clears interrupt mask and sets external interrupt enable.
// - Stop leaves every other register, memory and I/O unchanged.
// - Only external interrupt or reset wakes from stop.
// - Stop exit restarts oscillator and waits 4064 or 16 cycles.
// - Halt gates processor clock, timer clocks keep running.
// - Halt exits on timer interrupt, external interrupt or reset.
// - Halt exit waits for free-running stabilization counter to complete.
// - Wait stops processor clock; timer clocks keep running.
// - Wait instruction clears interrupt mask and sets external interrupt enable.
// - Wait exits on enabled timer interrupt, external interrupt or reset.
// - Wait and halt keep all other state unchanged.
// - Short select sets stabilization count to 16, also at power-up; reset here enters run with no stabilization wait.
`timescale 1ns/1ps
`include "lpm_consts.svh"
module lpm_ctrl
  import lpm_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic resetn_in,
  input  wire logic stop_req_in,
  input  wire logic wait_req_in,
  input  wire logic stop_to_halt_select_in,
  input  wire logic short_stabilization_select_in,
  input  wire logic ext_irq_in,
  input  wire logic timer_irq_in,
  output logic      osc_enable_out,
  output logic      cpu_clk_enable_out,
  output logic      timer_clk_enable_out,
  output logic      watchdog_run_out,
  output logic      timer_bits_clear_out,
  output logic      int_mask_clear_out,
  output logic      external_int_enable_set_out,
  output logic      wake_service_out,
  output logic      stopped_out
);
  typedef logic [`LPM_CNT_W-1:0] lpm_cnt_t;

  logic       ext_s1, ext_s2, tmr_s1, tmr_s2;
  lpm_state_e state, next_state;
  lpm_cnt_t   stab_cnt, next_stab_cnt;
  lpm_cnt_t   free_cnt, next_free_cnt;
  lpm_cnt_t   limit;
  logic       next_osc, next_cpu, next_tmr, next_wdog, next_tclr, next_iclr;
  logic       next_iset, next_wsvc, next_stopped;
  logic       free_done;
  logic       next_ext_s1, next_ext_s2, next_tmr_s1, next_tmr_s2;

  // Two-stage synchronisers for the asynchronous wake sources.
  // Only the second stage is read by the mode logic, to keep metastability out.
  always_comb begin
    next_ext_s1 = ext_irq_in;
    next_ext_s2 = ext_s1;
    next_tmr_s1 = timer_irq_in;
    next_tmr_s2 = tmr_s1;
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      tmr_s1 <= 1'b0;
      tmr_s2 <= 1'b0;
    end else begin
      ext_s1 <= next_ext_s1;
      ext_s2 <= next_ext_s2;
      tmr_s1 <= next_tmr_s1;
      tmr_s2 <= next_tmr_s2;
    end
  end

  assign limit     = short_stabilization_select_in ? `LPM_SHORT_DELAY : `LPM_LONG_DELAY;
  // A greater-or-equal test keeps the counter from running to wrap-around
  // when the delay select drops from the long to the short count mid-count.
  assign free_done = (free_cnt >= limit - 12'd1);

  always_comb begin
    next_state    = state;
    next_stab_cnt = stab_cnt;
    // The free-running counter models the stabilization timer outside stop and holds during the stop-exit stabilization wait.
    next_free_cnt = free_done ? 12'h000 : free_cnt + 12'd1;
    next_tclr     = 1'b0;
    next_iclr     = 1'b0;
    next_iset     = 1'b0;
    next_wsvc     = 1'b0;
    case (state)
      LPM_RUN: begin
        if (stop_req_in) begin
          next_iclr = 1'b1;
          next_iset = 1'b1;
          if (stop_to_halt_select_in) begin
            next_state = LPM_HALT;
          end else begin
            next_state = LPM_STOP;
            next_tclr  = 1'b1;
          end
        end else if (wait_req_in) begin
          next_iclr  = 1'b1;
          next_iset  = 1'b1;
          next_state = LPM_WAIT;
        end
      end
      LPM_STOP: begin
        // Timer events are ignored here since their clock is off.
        next_free_cnt = free_cnt;
        if (ext_s2) begin
          next_state    = LPM_STAB;
          next_stab_cnt = 12'h000;
        end
      end
      LPM_STAB: begin
        next_free_cnt = free_cnt;
        next_stab_cnt = stab_cnt + 12'd1;
        if (stab_cnt >= limit - 12'd1) begin
          next_state = LPM_RUN;
          next_wsvc  = 1'b1;
        end
      end
      LPM_HALT: begin
        if (ext_s2 || tmr_s2) begin
          next_state = LPM_HALT_EXIT;
        end
      end
      LPM_HALT_EXIT: begin
        if (free_done) begin
          next_state = LPM_RUN;
          next_wsvc  = 1'b1;
        end
      end
      LPM_WAIT: begin
        if (ext_s2 || tmr_s2) begin
          next_state = LPM_RUN;
          next_wsvc  = 1'b1;
        end
      end
      default: next_state = LPM_RUN;
    endcase
    // Only the two interrupt bits and timer bits are touched; all else holds.
    next_osc     = (next_state != LPM_STOP);
    next_cpu     = (next_state == LPM_RUN);
    next_tmr     = (next_state != LPM_STOP) && (next_state != LPM_STAB);
    next_wdog    = next_tmr;
    next_stopped = (next_state != LPM_RUN);
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      state                       <= LPM_RUN;
      stab_cnt                    <= 12'h000;
      free_cnt                    <= 12'h000;
      osc_enable_out              <= 1'b1;
      cpu_clk_enable_out          <= 1'b1;
      timer_clk_enable_out        <= 1'b1;
      watchdog_run_out            <= 1'b1;
      timer_bits_clear_out        <= 1'b0;
      int_mask_clear_out          <= 1'b0;
      external_int_enable_set_out <= 1'b0;
      wake_service_out            <= 1'b0;
      stopped_out                 <= 1'b0;
    end else begin
      state                       <= next_state;
      stab_cnt                    <= next_stab_cnt;
      free_cnt                    <= next_free_cnt;
      osc_enable_out              <= next_osc;
      cpu_clk_enable_out          <= next_cpu;
      timer_clk_enable_out        <= next_tmr;
      watchdog_run_out            <= next_wdog;
      timer_bits_clear_out        <= next_tclr;
      int_mask_clear_out          <= next_iclr;
      external_int_enable_set_out <= next_iset;
      wake_service_out            <= next_wsvc;
      stopped_out                 <= next_stopped;
    end
  end

  chk_stop_osc_off: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (state == LPM_RUN && stop_req_in && !stop_to_halt_select_in) |=> !osc_enable_out
      && timer_bits_clear_out) else $error("stop entry wrong");
  chk_halt_keeps_osc: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (state == LPM_RUN && stop_req_in && stop_to_halt_select_in) |=> osc_enable_out
      && !cpu_clk_enable_out && timer_clk_enable_out) else $error("halt entry wrong");
  chk_stop_int_bits: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (state == LPM_RUN && stop_req_in) |=> int_mask_clear_out && external_int_enable_set_out)
    else $error("stop int bits wrong");
  chk_wait_int_bits: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (state == LPM_RUN && !stop_req_in && wait_req_in) |=> int_mask_clear_out
      && !timer_bits_clear_out && !cpu_clk_enable_out) else $error("wait entry wrong");
  chk_stop_no_timer: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (state == LPM_STOP && !ext_s2) |=> state == LPM_STOP) else $error("stop woke");
  chk_stab_short: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (state == LPM_STOP && ext_s2 && short_stabilization_select_in) ##1
      (short_stabilization_select_in [*8]) |-> ##8 !cpu_clk_enable_out ##1 cpu_clk_enable_out)
    else $error("short delay wrong");
  chk_wait_wake: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (state == LPM_WAIT && tmr_s2) |=> cpu_clk_enable_out && wake_service_out)
    else $error("wait wake wrong");
  chk_halt_exit_bound: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (state == LPM_HALT_EXIT && short_stabilization_select_in) |-> ##[1:17] state == LPM_RUN)
    else $error("halt exit slow");

  // The clock enables of each settled mode are checked against the state itself.
  chk_stop_clocks_off: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (state == LPM_STOP) |-> !osc_enable_out && !watchdog_run_out && !timer_clk_enable_out)
    else $error("stop clocks wrong");

  chk_halt_clocks_on: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (state == LPM_HALT) |-> osc_enable_out && !cpu_clk_enable_out && timer_clk_enable_out
      && watchdog_run_out)
    else $error("halt clocks wrong");

  chk_wait_clocks_on: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (state == LPM_WAIT) |-> osc_enable_out && !cpu_clk_enable_out && timer_clk_enable_out
      && watchdog_run_out)
    else $error("wait clocks wrong");

  chk_stab_clocks: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (state == LPM_STAB) |-> osc_enable_out && !cpu_clk_enable_out && !timer_clk_enable_out)
    else $error("stabilization clocks wrong");

  chk_run_clocks_on: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (state == LPM_RUN) |-> osc_enable_out && cpu_clk_enable_out && !stopped_out)
    else $error("run clocks wrong");

  chk_halt_no_clear: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (state == LPM_RUN && stop_req_in && stop_to_halt_select_in) |=> !timer_bits_clear_out)
    else $error("halt cleared timer bits");

  // Requests that arrive while already asleep or waking must not restart entry.
  chk_busy_ignores_req: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (state != LPM_RUN && (stop_req_in || wait_req_in)) |=> !int_mask_clear_out)
    else $error("request taken outside run");

  chk_halt_holds: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (state == LPM_HALT && !ext_s2 && !tmr_s2) |=> state == LPM_HALT)
    else $error("halt left without cause");

  chk_wait_holds: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (state == LPM_WAIT && !ext_s2 && !tmr_s2) |=> state == LPM_WAIT)
    else $error("wait left without cause");

  chk_stop_timer_ignored: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (state == LPM_STOP && tmr_s2 && !ext_s2) |=> stopped_out && !osc_enable_out)
    else $error("timer woke stop");

  chk_halt_exit_waits: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (state == LPM_HALT_EXIT && !free_done) |=> state == LPM_HALT_EXIT)
    else $error("halt exit early");

  chk_wake_single: assert property (@(posedge clk_in) disable iff (!resetn_in)
    wake_service_out |=> !wake_service_out)
    else $error("wake pulse too long");

  chk_int_bits_pair: assert property (@(posedge clk_in) disable iff (!resetn_in)
    int_mask_clear_out |-> external_int_enable_set_out && stopped_out)
    else $error("interrupt bits unpaired");

  chk_stab_exit_clk: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (state == LPM_STAB && next_state == LPM_RUN) |=> cpu_clk_enable_out && wake_service_out)
    else $error("stabilization exit wrong");

  chk_entry_stopped: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (state == LPM_RUN && (stop_req_in || wait_req_in)) |=> stopped_out && !wake_service_out)
    else $error("entry not stopped");

  cov_stop: cover property (@(posedge clk_in) state == LPM_STAB ##1 state == LPM_RUN);
  cov_halt: cover property (@(posedge clk_in) state == LPM_HALT_EXIT ##1 state == LPM_RUN);
  cov_wait: cover property (@(posedge clk_in) state == LPM_WAIT ##1 state == LPM_RUN);
  cov_stop_tmr: cover property (@(posedge clk_in) state == LPM_STOP && tmr_s2);
  cov_both_req: cover property (@(posedge clk_in) state == LPM_RUN && stop_req_in && wait_req_in);
endmodule

// ==== test/lpm_core_model.sv ====
// Purpose: Processor core model that issues stop and wait and resumes on wake.
// Assumes: Instructions are issued as one-cycle pulses driven just after a rising edge.
// Notes:   The wake counter lets the bench see whether a wake slipped through.
`timescale 1ns/1ps
module lpm_core_model (
  input  wire logic       clk_in,
  input  wire logic       wake_service_in,
  output logic            stop_req_out,
  output logic            wait_req_out,
  output logic [7:0]      wakes_out
);
  initial begin
    stop_req_out = 1'b0;
    wait_req_out = 1'b0;
    wakes_out    = 8'h00;
  end
  // The core counts each resume, since it must service the waking interrupt first.
  always @(posedge clk_in) begin
    if (wake_service_in === 1'b1) begin
      wakes_out <= wakes_out + 8'h01;
    end
  end
  // A stop may come with a simultaneous wait pulse; stop must win.
  task automatic exec(input logic is_stop, input logic also_wait);
    @(posedge clk_in);
    #2;
    stop_req_out = is_stop;
    wait_req_out = !is_stop || also_wait;
    @(posedge clk_in);
    #2;
    stop_req_out = 1'b0;
    wait_req_out = 1'b0;
  endtask
endmodule

// ==== test/tb_low_power_mode_control.sv ====
// Purpose: Self-checking bench for the low-power mode controller.
// Assumes: Short delays are 16 cycles; one long stop exercises the full count.
// Notes:   Entry pulses are queued by the driver and compared by a monitor.
`timescale 1ns/1ps
module tb_low_power_mode_control;
  import lpm_pkg::*;
  logic clk_in = 1'b0, resetn_in = 1'b0, halt_sel = 1'b0, short_sel = 1'b1;
  logic ext_irq = 1'b0, tmr_irq = 1'b0, stop_req, wait_req, osc, cpu, tclk, wdog;
  logic tbc, imc, iset, wake, stopped;
  logic [7:0] wakes;
  logic [5:0] exp_q[$];
  int n_errors = 0, checked = 0;
  always #12.5 clk_in = ~clk_in;
  lpm_core_model lpm_core_model_i (.clk_in(clk_in), .wake_service_in(wake),
    .stop_req_out(stop_req), .wait_req_out(wait_req), .wakes_out(wakes));
  lpm_ctrl lpm_ctrl_i (.clk_in(clk_in), .resetn_in(resetn_in), .stop_req_in(stop_req),
    .wait_req_in(wait_req), .stop_to_halt_select_in(halt_sel),
    .short_stabilization_select_in(short_sel), .ext_irq_in(ext_irq), .timer_irq_in(tmr_irq),
    .osc_enable_out(osc), .cpu_clk_enable_out(cpu), .timer_clk_enable_out(tclk),
    .watchdog_run_out(wdog), .timer_bits_clear_out(tbc), .int_mask_clear_out(imc),
    .external_int_enable_set_out(iset), .wake_service_out(wake), .stopped_out(stopped));
  task automatic chk(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  task automatic close_out;
    $display("Counts: checked=%0d n_errors=%0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Entry pulses and the clock enables of the new mode are judged together.
  always @(posedge clk_in) begin
    #1;
    if (imc === 1'b1) begin
      if (exp_q.size() == 0) chk(1'b0, "entry pulse with nothing expected");
      else chk({tbc, imc, iset, osc, cpu, tclk} === exp_q.pop_front(), "entry state");
    end
  end
  task automatic run(input logic is_stop, sel, sshort, use_ext, input int lo, hi);
    int n;
    logic [7:0] w0;
    logic aw;
    @(posedge clk_in);
    #2;
    halt_sel = sel;
    short_sel = sshort;
    repeat ($urandom % 4 + 1) @(posedge clk_in);
    exp_q.push_back((is_stop && !sel) ? 6'b111000 : 6'b011101);
    aw = 1'($urandom % 2);
    lpm_core_model_i.exec(is_stop, aw);
    chk(stopped === 1'b1 && wdog === !(is_stop && !sel), "mode held");
    if (is_stop && !sel) begin
      w0 = wakes;
      tmr_irq = 1'b1;
      repeat (30) @(posedge clk_in);
      #2;
      chk(wakes === w0 && stopped === 1'b1 && osc === 1'b0, "timer woke stop");
      tmr_irq = 1'b0;
    end
    @(posedge clk_in);
    #2;
    if (use_ext) ext_irq = 1'b1;
    else tmr_irq = 1'b1;
    for (n = 1; n <= hi + 5 && wake !== 1'b1; n++) begin
      @(posedge clk_in);
      #1;
    end
    if (n > hi + 5) begin
      chk(1'b0, "no wake");
      close_out();
    end else begin
      chk(n >= lo && n <= hi && cpu === 1'b1 && osc === 1'b1, "wake delay");
      #1;
      ext_irq = 1'b0;
      tmr_irq = 1'b0;
      repeat (4) @(posedge clk_in);
      #1;
      chk(stopped === 1'b0 && cpu === 1'b1, "back in run");
      $display("test done: stop=%0d halt_sel=%0d short=%0d", is_stop, sel, sshort);
    end
  endtask
  initial begin
    void'($urandom(45));
    repeat (10) @(posedge clk_in);
    #2;
    resetn_in = 1'b1;
    chk(osc === 1'b1 && cpu === 1'b1 && tclk === 1'b1 && stopped === 1'b0, "reset state");
    run(1'b0, 1'b0, 1'b1, 1'b0, 2, 4);
    run(1'b1, 1'b1, 1'b1, 1'b1, 3, 21);
    run(1'b1, 1'b1, 1'b1, 1'b0, 3, 21);
    run(1'b1, 1'b0, 1'b1, 1'b1, 17, 22);
    run(1'b1, 1'b0, 1'b0, 1'b1, 4065, 4070);
    chk(exp_q.size() == 0, "missing entry pulse");
    close_out();
  end
endmodule
